// ===== rtl/opwk_device.sv
// What this block does
// - Power-on reset enters power-up wait state
// - Power-up wakes on wake low over 10us
// - Hibernate wakes only on long wake low
// - Sleep wakes on timer, pin or select
// - Tag detect also wakes on detected tag
// - Ready keeps field off, awaits protocol choice
// - Reader exchanges tag and host frames
// - Low-power states entered only by host command
// - Low-power states stop host communication
// - Idle command parameters set tag-detect wake
// - Interface selected only after wake pulse
// - Ready follows fast oscillator setup, max 10ms
// - Wake pulse never taken as start bit
// - Host waits 100us before first wake pulse
// - Interface selection completes after 250ns
// - Straps latched on wake falling edge
// - Slave select is active low
// - Reset byte returns to power-up after deselect
module opwk_device
   import opwk_pkg::*;
#(
   parameter int unsigned FAST_SU_CYCLES = FAST_SU_CYC
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        arst_n,
   // Link to host
   opwk_if.device           lnk,
   // Command side from the command decoder
   input  wire logic        cmd_valid,
   input  wire opwk_cmd_t   cmd_kind,
   input  wire logic [3:0]  cmd_wake_mask,
   input  wire logic        proto_sel,
   input  wire logic        timer_evt,
   input  wire logic        tag_evt,
   // Status
   output opwk_state_t      state,
   output opwk_if_t         iface,
   output logic            low_power_wait_group,
   output logic            slow_oscillator,
   output logic            fast_oscillator,
   output logic            rf_field_on,
   output logic            host_comm_en,
   output logic            uart_rx_gate
);
   opwk_state_t      state_reg;
   opwk_state_t      state_next;
   opwk_if_t         iface_reg;
   logic [3:0]       wmask_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] low_cnt_reg;
   logic [2:0]       wk_sync_reg;
   logic [2:0]       sel_sync_reg;
   logic [1:0]       sa_sync_reg;
   logic [1:0]       sb_sync_reg;
   logic             rst_pend_reg;
   logic             long_low;
   logic             wake_fall;
   logic             sel_rise;
   logic             in_wait;
   logic             rf_reg;
   logic             comm_reg;
   logic             gate_reg;
   logic             wait_reg;
   logic             fast_reg;

   // One place decides the low-power wait group
   function automatic logic wait_of(input opwk_state_t s);
      return (s == OPWK_POWERUP) || (s == OPWK_HIBERNATE) ||
             (s == OPWK_SLEEP) || (s == OPWK_TAGDET);
   endfunction

   // Pins pass two flops before use; third stage for edges only
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         wk_sync_reg  <= 3'h7;
         sel_sync_reg <= 3'h7;
         sa_sync_reg  <= 2'h0;
         sb_sync_reg  <= 2'h0;
      end else begin
         wk_sync_reg  <= {wk_sync_reg[1:0], lnk.wake_rx_n};
         sel_sync_reg <= {sel_sync_reg[1:0], lnk.sel_n};
         sa_sync_reg  <= {sa_sync_reg[0], lnk.iface_strap_a};
         sb_sync_reg  <= {sb_sync_reg[0], lnk.iface_strap_b};
      end
   end

   assign wake_fall = wk_sync_reg[2] & ~wk_sync_reg[1];
   assign sel_rise  = ~sel_sync_reg[2] & sel_sync_reg[1];
   assign long_low  = (low_cnt_reg >= CNT_W'(WAKE_MIN_CYC));
   assign in_wait   = wait_of(state_reg);

   // Wake-low width; saturates so a held pin cannot wrap
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         low_cnt_reg <= '0;
      end else if (wk_sync_reg[1]) begin
         low_cnt_reg <= '0;
      end else if (!long_low) begin
         low_cnt_reg <= low_cnt_reg + CNT_W'(1);
      end
   end

   // Next state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         OPWK_POWERUP, OPWK_HIBERNATE: begin
            if (long_low) begin
               state_next = OPWK_IFSEL;
            end
         end
         OPWK_SLEEP: begin
            if ((wmask_reg[WK_TIMER] && timer_evt) ||
                (wmask_reg[WK_PIN] && long_low) ||
                (wmask_reg[WK_SEL] && !sel_sync_reg[1])) begin
               state_next = OPWK_READY;
            end
         end
         OPWK_TAGDET: begin
            if ((wmask_reg[WK_TIMER] && timer_evt) ||
                (wmask_reg[WK_PIN] && long_low) ||
                (wmask_reg[WK_SEL] && !sel_sync_reg[1]) ||
                (wmask_reg[WK_TAG] && tag_evt)) begin
               state_next = OPWK_READY;
            end
         end
         OPWK_IFSEL: begin
            if (cnt_reg >= CNT_W'(FAST_SU_CYCLES)) begin
               state_next = OPWK_READY;
            end
         end
         OPWK_READY, OPWK_READER: begin
            if (cmd_valid) begin
               case (cmd_kind)
                  OPWK_CMD_HIBERNATE: state_next = OPWK_HIBERNATE;
                  OPWK_CMD_SLEEP:     state_next = OPWK_SLEEP;
                  OPWK_CMD_TAGDET:    state_next = OPWK_TAGDET;
                  default:            state_next = state_reg;
               endcase
            end else if (state_reg == OPWK_READY && proto_sel) begin
               state_next = OPWK_READER;
            end
         end
         default: state_next = OPWK_POWERUP;
      endcase
      if (rst_pend_reg && sel_rise && !in_wait) begin
         state_next = OPWK_POWERUP;
      end
   end

   // State register
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= OPWK_POWERUP;
      end else begin
         state_reg <= state_next;
      end
   end

   // Setup counter runs only while selecting the interface
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= '0;
      end else if (state_reg != OPWK_IFSEL) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_reg + CNT_W'(1);
      end
   end

   // Straps caught at wake fall out of power-up or hibernate
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         iface_reg <= OPWK_IF_NONE;
      end else if (wake_fall && (state_reg == OPWK_POWERUP ||
                                 state_reg == OPWK_HIBERNATE)) begin
         iface_reg <= opwk_decode(sa_sync_reg[1], sb_sync_reg[1]);
      end
   end

   // Wake sources taken from the idle command
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         wmask_reg <= WK_RESET;
      end else if (cmd_valid && (state_reg == OPWK_READY ||
                                 state_reg == OPWK_READER)) begin
         wmask_reg <= cmd_wake_mask;
      end
   end

   // Reset byte waits for deselect; cleared once taken
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rst_pend_reg <= 1'b0;
      end else if (lnk.reset_byte && iface_reg == OPWK_IF_SPI) begin
         rst_pend_reg <= 1'b1;
      end else if (sel_rise || in_wait) begin
         rst_pend_reg <= 1'b0;
      end
   end

   // Registered status outputs
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rf_reg   <= 1'b0;
         comm_reg <= 1'b0;
         gate_reg <= 1'b0;
         wait_reg <= 1'b1;
         fast_reg <= 1'b0;
      end else begin
         // Taken from the next state so flags line up with state
         wait_reg <= wait_of(state_next);
         fast_reg <= !wait_of(state_next);
         rf_reg   <= (state_next == OPWK_READER);
         comm_reg <= (state_next == OPWK_READY) ||
                     (state_next == OPWK_READER);
         // Receiver held off until wake pin is back high
         gate_reg <= (state_next == OPWK_READY ||
                      state_next == OPWK_READER) &&
                     (iface_reg == OPWK_IF_UART) &&
                     wk_sync_reg[1] &&
                     (gate_reg || state_reg == state_next);
      end
   end

   assign state                = state_reg;
   assign iface                = iface_reg;
   assign low_power_wait_group = wait_reg;
   assign slow_oscillator      = wait_reg;
   assign fast_oscillator      = fast_reg;
   assign rf_field_on          = rf_reg;
   assign host_comm_en         = comm_reg;
   assign uart_rx_gate         = gate_reg;
endmodule

// ===== rtl/opwk_host.sv
// Host end: power-on delay, wake pulse, straps, select, reset byte
module opwk_host
   import opwk_pkg::*;
#(
   parameter int unsigned PWRUP_CYCLES = PWRUP_DLY_CYC
) (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       arst_n,
   // Link to device
   opwk_if.host            lnk,
   // User requests
   input  wire logic       use_spi,
   input  wire logic       wake_req,
   input  wire logic       sel_req,
   input  wire logic       reset_req,
   // Status
   output logic            busy
);
   opwk_hstate_t     hst_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic             wake_n_reg;
   logic             sel_n_reg;
   logic             sa_reg;
   logic             rst_reg;
   logic             first_reg;

   // Sequencer: wait after power-on, then long wake pulses
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         hst_reg    <= OPWK_H_INIT;
         cnt_reg    <= '0;
         wake_n_reg <= 1'b1;
         first_reg  <= 1'b1;
      end else begin
         case (hst_reg)
            OPWK_H_INIT: begin
               cnt_reg <= cnt_reg + CNT_W'(1);
               if (cnt_reg >= CNT_W'(PWRUP_CYCLES)) begin
                  hst_reg    <= OPWK_H_PULSE;
                  cnt_reg    <= '0;
                  wake_n_reg <= 1'b0;
               end
            end
            OPWK_H_PULSE: begin
               cnt_reg <= cnt_reg + CNT_W'(1);
               // Margin over minimum covers device synchroniser
               if (cnt_reg >= CNT_W'(HOST_PULSE_CYC)) begin
                  hst_reg    <= OPWK_H_WAIT;
                  wake_n_reg <= 1'b1;
                  cnt_reg    <= '0;
               end
            end
            OPWK_H_WAIT: begin
               first_reg <= 1'b0;
               cnt_reg   <= cnt_reg + CNT_W'(1);
               if (cnt_reg >= CNT_W'(IFSEL_CYC)) begin
                  hst_reg <= OPWK_H_IDLE;
               end
            end
            OPWK_H_IDLE: begin
               if (wake_req) begin
                  hst_reg    <= OPWK_H_PULSE;
                  cnt_reg    <= '0;
                  wake_n_reg <= 1'b0;
               end
            end
            default: hst_reg <= OPWK_H_INIT;
         endcase
      end
   end

   // Straps held steady; changed only in init or idle
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sa_reg <= 1'b0;
      end else if (hst_reg == OPWK_H_INIT || hst_reg == OPWK_H_IDLE) begin
         sa_reg <= use_spi;
      end
   end

   // Select and reset byte
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sel_n_reg <= 1'b1;
         rst_reg   <= 1'b0;
      end else begin
         sel_n_reg <= ~(sel_req || reset_req);
         rst_reg   <= reset_req && sel_n_reg;
      end
   end

   assign lnk.wake_rx_n     = wake_n_reg;
   assign lnk.sel_n         = sel_n_reg;
   assign lnk.iface_strap_a = sa_reg;
   assign lnk.iface_strap_b = 1'b0;
   assign lnk.reset_byte    = rst_reg;
   assign busy              = (hst_reg != OPWK_H_IDLE) | first_reg;
endmodule

// ===== rtl/opwk_if.sv
interface opwk_if;
   import opwk_pkg::*;
   logic wake_rx_n;      // Shared receive / wake pin, active low
   logic sel_n;          // Serial slave select, active low
   logic iface_strap_a;  // Interface strap, first pin
   logic iface_strap_b;  // Interface strap, second pin
   logic reset_byte;     // Pulse: SPI reset control byte seen
   modport device (input wake_rx_n, input sel_n, input iface_strap_a,
                   input iface_strap_b, input reset_byte);
   modport host   (output wake_rx_n, output sel_n, output iface_strap_a,
                   output iface_strap_b, output reset_byte);
endinterface

// ===== rtl/opwk_pkg.sv
package opwk_pkg;
   // Clock rate and derived counts
   localparam int unsigned CLK_MHZ        = 200;
   localparam int unsigned CLK_PERIOD_NS  = 5;
   localparam int unsigned WAKE_MIN_US    = 10;
   localparam int unsigned WAKE_MIN_CYC   = WAKE_MIN_US * CLK_MHZ;
   localparam int unsigned IFSEL_NS       = 250;
   localparam int unsigned IFSEL_CYC      = IFSEL_NS / CLK_PERIOD_NS;
   localparam int unsigned FAST_SU_MS     = 10;
   localparam int unsigned FAST_SU_CYC    = FAST_SU_MS * 1000 * CLK_MHZ;
   localparam int unsigned PWRUP_DLY_US   = 100;
   localparam int unsigned PWRUP_DLY_CYC  = PWRUP_DLY_US * CLK_MHZ;
   localparam int unsigned CNT_W          = 24;
   localparam int unsigned HOST_PULSE_CYC = WAKE_MIN_CYC + 20;

   // SPI reset control byte
   localparam logic [7:0] CTRL_RESET = 8'h01;

   // Wake source mask bit positions
   localparam int unsigned WK_TIMER = 0;
   localparam int unsigned WK_PIN   = 1;
   localparam int unsigned WK_SEL   = 2;
   localparam int unsigned WK_TAG   = 3;
   localparam logic [3:0] WK_RESET  = 4'h0;

   // Requested low-power entry commands
   typedef enum logic [1:0] {
      OPWK_CMD_HIBERNATE = 2'h0,
      OPWK_CMD_SLEEP     = 2'h1,
      OPWK_CMD_TAGDET    = 2'h2
   } opwk_cmd_t;

   // Selected serial interface
   typedef enum logic [1:0] {
      OPWK_IF_NONE = 2'h0,
      OPWK_IF_UART = 2'h1,
      OPWK_IF_SPI  = 2'h2
   } opwk_if_t;

   // Device operating states
   typedef enum logic [6:0] {
      OPWK_POWERUP   = 7'h01,
      OPWK_HIBERNATE = 7'h02,
      OPWK_SLEEP     = 7'h04,
      OPWK_TAGDET    = 7'h08,
      OPWK_IFSEL     = 7'h10,
      OPWK_READY     = 7'h20,
      OPWK_READER    = 7'h40
   } opwk_state_t;

   // Host sequencer states
   typedef enum logic [3:0] {
      OPWK_H_INIT  = 4'h1,
      OPWK_H_PULSE = 4'h2,
      OPWK_H_WAIT  = 4'h4,
      OPWK_H_IDLE  = 4'h8
   } opwk_hstate_t;

   // Strap decode, used by the device end
   function automatic opwk_if_t opwk_decode(input logic a, input logic b);
      if (a && !b) begin
         return OPWK_IF_SPI;
      end else if (!a && !b) begin
         return OPWK_IF_UART;
      end
      return OPWK_IF_NONE;
   endfunction
endpackage

// ===== verif/opwk_link_checker.sv
module opwk_link_checker
   import opwk_pkg::*;
#(
   parameter int unsigned FAST_SU_CYCLES = FAST_SU_CYC
) (
   // Clock and reset
   input wire logic        mclk,
   input wire logic        arst_n,
   // Link pins
   input wire logic        wake_rx_n,
   input wire logic        sel_n,
   input wire logic        iface_strap_a,
   input wire logic        iface_strap_b,
   input wire logic        reset_byte,
   // Device side
   input wire logic        cmd_valid,
   input wire opwk_state_t state,
   input wire opwk_if_t    iface,
   input wire logic        low_power_wait_group,
   input wire logic        slow_oscillator,
   input wire logic        fast_oscillator,
   input wire logic        rf_field_on,
   input wire logic        host_comm_en,
   input wire logic        uart_rx_gate
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   logic [15:0] low_cnt;
   int unsigned su_cnt;
   logic        rb_pend;

   // Length of the present low level on the wake pin
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         low_cnt <= 16'h0000;
      end else if (wake_rx_n) begin
         low_cnt <= 16'h0000;
      end else if (low_cnt != 16'hFFFF) begin
         low_cnt <= low_cnt + 16'h0001;
      end
   end

   // Cycles spent in selection; counter, since setup may be millions
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         su_cnt <= 0;
      end else begin
         su_cnt <= (state == OPWK_IFSEL) ? su_cnt + 1 : 0;
      end
   end

   // Reset byte seen, return still owed
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rb_pend <= 1'b0;
      end else if (state == OPWK_POWERUP) begin
         rb_pend <= 1'b0;
      end else if (reset_byte && iface == OPWK_IF_SPI) begin
         rb_pend <= 1'b1;
      end
   end

   sequence s_deselect;
      rb_pend && $rose(sel_n);
   endsequence

   a_reset_to_powerup: assert property (
      $rose(arst_n) |-> state == OPWK_POWERUP)
      else $error("state not power-up after reset");
   a_wait_group_osc: assert property (
      low_power_wait_group == (state inside {OPWK_POWERUP, OPWK_HIBERNATE,
      OPWK_SLEEP, OPWK_TAGDET}) && slow_oscillator == low_power_wait_group
      && fast_oscillator == !low_power_wait_group)
      else $error("wait group or oscillator flags wrong");
   a_long_wake_only: assert property (
      state == OPWK_IFSEL && $past(state) inside {OPWK_POWERUP,
      OPWK_HIBERNATE} |-> low_cnt >= WAKE_MIN_CYC)
      else $error("woke on a short low pulse");
   a_setup_span: assert property (
      state == OPWK_READY && $past(state) == OPWK_IFSEL |->
      su_cnt + 2 >= FAST_SU_CYCLES && su_cnt <= FAST_SU_CYCLES + 3)
      else $error("fast oscillator setup span wrong");
   a_ready_field_off: assert property (
      state == OPWK_READY |-> !rf_field_on)
      else $error("field on in ready");
   a_sleep_no_comm: assert property (
      low_power_wait_group && $past(low_power_wait_group) |->
      !host_comm_en && !uart_rx_gate)
      else $error("host link active in wait state");
   a_entry_by_cmd: assert property (
      state != $past(state) && state inside {OPWK_HIBERNATE, OPWK_SLEEP,
      OPWK_TAGDET} |-> $past(cmd_valid))
      else $error("low-power entry without command");
   a_iface_latch_only: assert property (
      $changed(iface) |-> $past(state) inside {OPWK_POWERUP, OPWK_HIBERNATE})
      else $error("interface changed outside latch");
   a_strap_decode: assert property (
      $changed(iface) |-> iface == ((iface_strap_a && !iface_strap_b) ?
      OPWK_IF_SPI : (!iface_strap_a && !iface_strap_b) ? OPWK_IF_UART :
      OPWK_IF_NONE))
      else $error("strap decode wrong");
   a_gate_after_wake: assert property (
      $rose(uart_rx_gate) |-> wake_rx_n && $past(wake_rx_n))
      else $error("receive gate opened during wake pulse");
   a_reset_byte_ret: assert property (
      s_deselect |-> ##[1:6] state == OPWK_POWERUP)
      else $error("no power-up after reset byte");
endmodule

// ===== verif/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import opwk_pkg::*;
   localparam int unsigned SU = 100;
   logic        mclk, arst_n, use_spi, wake_req, sel_req, reset_req, busy;
   logic        cmd_valid, proto_sel, timer_evt, tag_evt;
   logic        low_power_wait_group, slow_oscillator, fast_oscillator;
   logic        rf_field_on, host_comm_en, uart_rx_gate;
   logic [3:0]  cmd_wake_mask;
   logic [31:0] rng;
   opwk_cmd_t   cmd_kind, kd;
   opwk_state_t state, exp_st;
   opwk_if_t    iface, e_if;
   opwk_if_t    exp_if_q[$];
   int          miscompares, comparisons, k, src, oth;

   opwk_if u_opwk_if ();
   opwk_device #(.FAST_SU_CYCLES(SU)) u_opwk_device (
      .mclk(mclk), .arst_n(arst_n), .lnk(u_opwk_if),
      .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
      .cmd_wake_mask(cmd_wake_mask), .proto_sel(proto_sel),
      .timer_evt(timer_evt), .tag_evt(tag_evt), .state(state),
      .iface(iface), .low_power_wait_group(low_power_wait_group),
      .slow_oscillator(slow_oscillator), .fast_oscillator(fast_oscillator),
      .rf_field_on(rf_field_on), .host_comm_en(host_comm_en),
      .uart_rx_gate(uart_rx_gate));
   opwk_host #(.PWRUP_CYCLES(50)) u_opwk_host (
      .mclk(mclk), .arst_n(arst_n), .lnk(u_opwk_if), .use_spi(use_spi),
      .wake_req(wake_req), .sel_req(sel_req), .reset_req(reset_req),
      .busy(busy));
   opwk_link_checker #(.FAST_SU_CYCLES(SU)) u_opwk_link_checker (
      .mclk(mclk), .arst_n(arst_n), .wake_rx_n(u_opwk_if.wake_rx_n),
      .sel_n(u_opwk_if.sel_n), .iface_strap_a(u_opwk_if.iface_strap_a),
      .iface_strap_b(u_opwk_if.iface_strap_b),
      .reset_byte(u_opwk_if.reset_byte), .cmd_valid(cmd_valid),
      .state(state), .iface(iface),
      .low_power_wait_group(low_power_wait_group),
      .slow_oscillator(slow_oscillator), .fast_oscillator(fast_oscillator),
      .rf_field_on(rf_field_on), .host_comm_en(host_comm_en),
      .uart_rx_gate(uart_rx_gate));

   // 200 MHz clock
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // Expected low-power state for an accepted command
   function automatic opwk_state_t lp_of(input opwk_cmd_t c);
      return c == OPWK_CMD_HIBERNATE ? OPWK_HIBERNATE :
             c == OPWK_CMD_SLEEP ? OPWK_SLEEP : OPWK_TAGDET;
   endfunction

   task automatic chk(input string nm, input logic [6:0] e,
                      input logic [6:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Sample a little after the edge so updates have landed
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic wait_st(input opwk_state_t s, input int lim);
      int i;
      for (i = 0; i < lim && state !== s; i++) begin
         tick(1);
      end
      exp_st = s;
      chk("state", s, state);
   endtask

   // Host sequences can run for a full wake pulse
   task automatic idle;
      int i;
      for (i = 0; i < 5000 && busy !== 1'b0; i++) begin
         tick(1);
      end
   endtask

   task automatic command(input opwk_cmd_t c, input logic [3:0] m);
      @(posedge mclk);
      cmd_kind <= c;
      cmd_wake_mask <= m;
      cmd_valid <= 1'b1;
      @(posedge mclk);
      cmd_valid <= 1'b0;
      if (exp_st inside {OPWK_READY, OPWK_READER}) begin
         exp_st = lp_of(c);
      end
      tick(1);
      chk("state", exp_st, state);
   endtask

   // Raise one wake source or request for four cycles
   task automatic fire(input int s);
      @(posedge mclk);
      case (s)
         WK_TIMER: timer_evt <= 1'b1;
         WK_PIN:   wake_req <= 1'b1;
         WK_SEL:   sel_req <= 1'b1;
         4:        reset_req <= 1'b1;
         default:  tag_evt <= 1'b1;
      endcase
      repeat (4) @(posedge mclk);
      {timer_evt, wake_req, sel_req, reset_req, tag_evt} <= 5'h00;
   endtask

   task automatic close_out;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Cut a hang short
   initial begin
      repeat (60000) @(posedge mclk);
      miscompares++;
      close_out;
   end

   // Main sequence
   initial begin
      {arst_n, wake_req, sel_req, reset_req, cmd_valid} = 5'h00;
      {proto_sel, timer_evt, tag_evt} = 3'h0;
      cmd_kind = OPWK_CMD_SLEEP;
      cmd_wake_mask = 4'h0;
      rng = xs(32'h0001150C);
      use_spi = rng[0];
      exp_st = OPWK_POWERUP;
      repeat (20) @(posedge mclk);
      arst_n <= 1'b1;
      tick(1);
      chk("state", OPWK_POWERUP, state);
      chk("iface", OPWK_IF_NONE, iface);
      command(OPWK_CMD_SLEEP, 4'hF);
      exp_if_q.push_back(use_spi ? OPWK_IF_SPI : OPWK_IF_UART);
      wait_st(OPWK_READY, 4000);
      e_if = exp_if_q.pop_front();
      chk("iface", e_if, iface);
      chk("field", 0, rf_field_on);
      idle;
      tick(2);
      chk("rxgate", e_if == OPWK_IF_UART, uart_rx_gate);
      @(posedge mclk) use_spi <= ~use_spi;
      // Every wake source of sleep and tag detect, first one that must not wake it (tag for sleep, even when its mask bit is set)
      for (k = 0; k < 7; k++) begin
         kd = k < 3 ? OPWK_CMD_SLEEP : OPWK_CMD_TAGDET;
         src = k < 3 ? k : k - 3;
         oth = k < 3 ? WK_TAG : (src == WK_TIMER ? WK_SEL : WK_TIMER);
         rng = xs(rng);
         command(kd, (4'h1 << src) | {k < 3 && rng[0], 3'h0});
         fire(oth);
         tick(10);
         chk("state", exp_st, state);
         chk("comm", 0, host_comm_en);
         chk("wait", 1, low_power_wait_group);
         chk("osc", 2'h2, {slow_oscillator, fast_oscillator});
         fire(src);
         wait_st(OPWK_READY, 3000);
         idle;
      end
      chk("iface", e_if, iface);
      command(OPWK_CMD_HIBERNATE, 4'hF);
      fire(WK_TIMER);
      fire(WK_SEL);
      tick(10);
      chk("state", OPWK_HIBERNATE, state);
      @(posedge mclk) use_spi <= 1'b1;
      exp_if_q.push_back(OPWK_IF_SPI);
      fire(WK_PIN);
      wait_st(OPWK_IFSEL, 2200);
      wait_st(OPWK_READY, 300);
      chk("iface", exp_if_q.pop_front(), iface);
      idle;
      @(posedge mclk) proto_sel <= 1'b1;
      @(posedge mclk) proto_sel <= 1'b0;
      wait_st(OPWK_READER, 3);
      chk("comm", 1, host_comm_en);
      chk("field", 1, rf_field_on);
      chk("rxgate", 0, uart_rx_gate);
      fire(4);
      wait_st(OPWK_POWERUP, 400);
      idle;
      fire(WK_PIN);
      wait_st(OPWK_READY, 2500);
      close_out;
   end
endmodule
